// >>> verilog/ttcr_top.sv
// Third timer: capture, auto-reload up/down and baud generator
// What this block does
// - 16-bit counter, timer or event counter
// - Free capture mode overflow sets overflow flag
// - Trigger fall copies count into reload bytes
// - Capture mode never reloads, keeps counting
// - Both flags share one readable interrupt
// - Down-count enable resets to zero
// - Up auto-reload: overflow sets flag, reloads
// - Trigger fall in up mode reloads too
// - Trigger pin level sets up/down direction
// - Up/down mode overflow sets flag, reloads
// - Down count hits reload: flag, load top
// - External flag toggles, no interrupt then
// - External flag set by trigger, software clears
// - Receive select picks this timer's overflow
// - Trigger ignored when disabled; baud mode: sets external flag only
// - Transmit select picks this timer's overflow
// - Baud mode rollover reloads, no flag
// - Baud mode internal clock counts state times
`timescale 1ns/100ps
`default_nettype none
module ttcr_top
    import ttcr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Pins
    input  wire logic       external_trigger_pin_in,
    input  wire logic       external_count_pin_in,
    // Serial port side
    input  wire logic       aux_timer_ovf_in,
    output logic            rx_baud_tick_out,
    output logic            tx_baud_tick_out,
    // Shared timer interrupt request
    output logic            timer_irq_out
);

    typedef struct packed {
        logic        overflow_flag;
        logic        external_flag;
        logic        rx_clock_select;
        logic        transmit_clock_select;
        logic        trigger_enable;
        logic        run_bit;
        logic        counter_select;
        logic        capture_reload_select;
        logic        down_count_enable;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0]  rdata;
        logic        irq;
        logic        rx_tick;
        logic        tx_tick;
    } ttcr_state_t;

    ttcr_state_t q;            // Registered state
    ttcr_state_t d;            // Next state

    logic trig_level;          // Clean trigger pin level
    logic trig_fall;           // Trigger falling edge
    logic count_fall;          // Count pin falling edge
    logic machine_tick;        // Once per machine cycle
    logic state_tick;          // Once per state time
    logic baud_mode;           // Either serial select set
    logic capture_mode;        // Capture selected, no baud
    logic updown_mode;         // Auto-reload with down enable
    logic count_down;          // Direction this cycle
    logic src_tick;            // Selected count source
    logic tick;                // Count enable this cycle
    logic ovf_ev;              // Rollover at top
    logic und_ev;              // Down count reached reload
    logic trig_ev;             // Enabled trigger edge
    logic capture_ev;          // Capture from trigger
    logic reload_ev;           // Reload from trigger
    logic wr_ctrl;             // Control register write
    logic wr_count;            // Count byte write
    logic wr_reload;           // Reload byte write

    // Control byte as software sees it
    function automatic logic [7:0] control_byte(input ttcr_state_t s);
        control_byte = {s.overflow_flag, s.external_flag, s.rx_clock_select,
                        s.transmit_clock_select, s.trigger_enable, s.run_bit,
                        s.counter_select, s.capture_reload_select};
    endfunction

    // Pin conditioning
    ttcr_sync u_trig_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (external_trigger_pin_in),
        .level_out (trig_level),
        .fall_out  (trig_fall)
    );

    ttcr_sync u_count_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (external_count_pin_in),
        .level_out (),
        .fall_out  (count_fall)
    );

    ttcr_prescale u_prescale (
        .clk_in           (clk_in),
        .rst_n_in         (rst_n_in),
        .machine_tick_out (machine_tick),
        .state_tick_out   (state_tick)
    );

    // Mode decode
    // serial selects force reload
    assign baud_mode    = q.rx_clock_select | q.transmit_clock_select;
    assign capture_mode = q.capture_reload_select & ~baud_mode;
    assign updown_mode  = q.down_count_enable & ~baud_mode & ~capture_mode;
    assign count_down   = updown_mode & ~trig_level;

    // Count source selection
    // timer or event counter
    assign src_tick = q.counter_select ? count_fall
                    : (baud_mode ? state_tick : machine_tick);
    assign tick = q.run_bit & src_tick;

    // Rollover and underflow detection
    assign ovf_ev = tick & ~count_down & (q.count == COUNT_TOP);
    assign und_ev = tick & count_down & (q.count == q.reload);

    // Trigger events
    // disabled trigger ignored
    assign trig_ev    = q.trigger_enable & trig_fall;
    assign capture_ev = trig_ev & capture_mode;
    // reload on enabled edge, up mode only
    assign reload_ev  = trig_ev & ~baud_mode & ~capture_mode & ~q.down_count_enable;

    // Software write decode
    assign wr_ctrl   = wr_in & (addr_in == ADDR_CONTROL);
    assign wr_count  = wr_in & ((addr_in == ADDR_COUNT_LOW) | (addr_in == ADDR_COUNT_HIGH));
    assign wr_reload = wr_in & ((addr_in == ADDR_RELOAD_LOW) | (addr_in == ADDR_RELOAD_HIGH));

    // Next-state logic: hardware, then software, then flag sets
    always_comb
    begin
        d = q;

        // Counter update
        if (und_ev)
            d.count = COUNT_TOP;
        else if ((ovf_ev & ~capture_mode) | reload_ev)
            d.count = q.reload;
        else if (tick)
            d.count = count_down ? q.count - 16'h0001 : q.count + 16'h0001;

        // Capture copies current count
        if (capture_ev)
            d.reload = q.count;

        // Software writes; count writes win over counting
        if (wr_in)
        begin
            unique case (addr_in)
                ADDR_CONTROL:
                begin
                    d.overflow_flag         = wdata_in[BIT_OVERFLOW];
                    d.external_flag         = wdata_in[BIT_EXTERNAL];
                    d.rx_clock_select       = wdata_in[BIT_RX_CLOCK];
                    d.transmit_clock_select = wdata_in[BIT_TX_CLOCK];
                    d.trigger_enable        = wdata_in[BIT_TRIG_EN];
                    d.run_bit               = wdata_in[BIT_RUN];
                    d.counter_select        = wdata_in[BIT_COUNTER];
                    d.capture_reload_select = wdata_in[BIT_CAPTURE];
                end
                ADDR_MODE:        d.down_count_enable = wdata_in[BIT_DOWN_EN];
                ADDR_COUNT_LOW:   d.count[7:0]   = wdata_in;
                ADDR_COUNT_HIGH:  d.count[15:8]  = wdata_in;
                ADDR_RELOAD_LOW:  d.reload[7:0]  = wdata_in;
                ADDR_RELOAD_HIGH: d.reload[15:8] = wdata_in;
                default:          ;
            endcase
        end

        // Flag sets win over a clear in the same cycle
        // overflow flag, not in baud mode
        if ((ovf_ev | und_ev) & ~baud_mode)
            d.overflow_flag = 1'b1;
        if (updown_mode & (ovf_ev | und_ev))
            d.external_flag = ~d.external_flag;
        // set by enabled trigger edge outside up/down mode
        else if (trig_ev & ~updown_mode)
            d.external_flag = 1'b1;

        d.irq = d.overflow_flag | (d.external_flag & ~d.down_count_enable);

        d.rx_tick = q.rx_clock_select ? ovf_ev : aux_timer_ovf_in;
        d.tx_tick = q.transmit_clock_select ? ovf_ev : aux_timer_ovf_in;

        // Read data stands one cycle only
        d.rdata = 8'h00;
        if (rd_in)
        begin
            unique case (addr_in)
                ADDR_CONTROL:     d.rdata = control_byte(q);
                ADDR_MODE:        d.rdata = {7'h00, q.down_count_enable};
                ADDR_COUNT_LOW:   d.rdata = q.count[7:0];
                ADDR_COUNT_HIGH:  d.rdata = q.count[15:8];
                ADDR_RELOAD_LOW:  d.rdata = q.reload[7:0];
                ADDR_RELOAD_HIGH: d.rdata = q.reload[15:8];
                default:          d.rdata = 8'h00;
            endcase
        end
    end

    // State register
    // down count off after reset
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
            q.count <= COUNT_RESET;
            q.reload <= RELOAD_RESET;
            q.down_count_enable <= MODE_RESET[BIT_DOWN_EN];
        end
        else
            q <= d;
    end

    // Outputs straight from flops
    assign rdata_out        = q.rdata;
    assign rx_baud_tick_out = q.rx_tick;
    assign tx_baud_tick_out = q.tx_tick;
    assign timer_irq_out    = q.irq;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_reset_upcount;
        @(posedge clk_in) disable iff (1'b0) !rst_n_in |=> !q.down_count_enable;
    endproperty
    a_reset_upcount: assert property (p_reset_upcount) else $error("down count on after reset");

    property p_ovf_flag;
        ovf_ev && !baud_mode |=> q.overflow_flag && timer_irq_out;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not raise flag");

    property p_capture_copy;
        capture_ev && !wr_reload |=> q.reload == $past(q.count);
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture value wrong");

    property p_capture_runs;
        capture_mode && tick && !wr_count |=> q.count == 16'($past(q.count) + 16'h0001);
    endproperty
    a_capture_runs: assert property (p_capture_runs) else $error("capture mode count broke");

    property p_reload_ovf;
        ovf_ev && !capture_mode && !wr_count |=> q.count == $past(q.reload);
    endproperty
    a_reload_ovf: assert property (p_reload_ovf) else $error("no reload on overflow");

    property p_underflow;
        und_ev && !wr_count |=> q.count == COUNT_TOP && q.overflow_flag;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow handling wrong");

    property p_ext_toggle;
        updown_mode && (ovf_ev || und_ev) && !wr_ctrl
            |=> q.external_flag != $past(q.external_flag);
    endproperty
    a_ext_toggle: assert property (p_ext_toggle) else $error("external flag did not toggle");

    property p_baud_no_flag;
        baud_mode && ovf_ev && !q.overflow_flag && !wr_ctrl |=> !q.overflow_flag;
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud rollover set flag");

    property p_stopped;
        !q.run_bit && !wr_count && !reload_ev |=> $stable(q.count);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counted while stopped");

    property p_rx_source;
        q.rx_clock_select && ovf_ev |=> rx_baud_tick_out;
    endproperty
    a_rx_source: assert property (p_rx_source) else $error("receive tick missing");

    c_capture:   cover property (capture_ev);
    c_underflow: cover property (und_ev ##1 q.overflow_flag);
    c_baud:      cover property (baud_mode && ovf_ev ##1 tx_baud_tick_out);

endmodule
`default_nettype wire

// >>> verilog/ttcr_pkg.sv
// Shared constants for the third timer with capture and reload
package ttcr_pkg;

    // Register addresses on the plain register port
    localparam logic [2:0] ADDR_CONTROL     = 3'h0;
    localparam logic [2:0] ADDR_MODE        = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LOW   = 3'h2;
    localparam logic [2:0] ADDR_COUNT_HIGH  = 3'h3;
    localparam logic [2:0] ADDR_RELOAD_LOW  = 3'h4;
    localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h5;

    // Control register bit positions
    localparam int BIT_OVERFLOW  = 7;
    localparam int BIT_EXTERNAL  = 6;
    localparam int BIT_RX_CLOCK  = 5;
    localparam int BIT_TX_CLOCK  = 4;
    localparam int BIT_TRIG_EN   = 3;
    localparam int BIT_RUN       = 2;
    localparam int BIT_COUNTER   = 1;
    localparam int BIT_CAPTURE   = 0;

    // Mode register bit position
    localparam int BIT_DOWN_EN   = 0;

    // Reset values
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] RELOAD_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_TOP     = 16'hffff;

    // Clock is the oscillator: 25 ns period
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MACHINE_NS      = 300;
    localparam int STATE_NS        = 50;
    localparam int MACHINE_CYCLES  = MACHINE_NS / CLK_PERIOD_NS;
    localparam int STATE_CYCLES    = STATE_NS / CLK_PERIOD_NS;
    localparam logic [3:0] MACHINE_LAST = 4'(MACHINE_CYCLES - 1);
    localparam logic [3:0] STATE_LAST   = 4'(STATE_CYCLES - 1);

endpackage

// >>> verilog/ttcr_sync.sv
// Pin synchroniser with a confirmed level and a falling-edge pulse
`timescale 1ns/100ps
`default_nettype none
module ttcr_sync
    import ttcr_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Raw pin
    input  wire logic pin_in,
    // Clean level and edge
    output logic      level_out,
    output logic      fall_out
);

    typedef struct packed {
        logic [2:0] stage;   // Stage 0 read only by stage 1
        logic       level;   // Confirmed level
        logic       fall;    // One-cycle falling pulse
    } ttcr_sync_t;

    ttcr_sync_t q;
    ttcr_sync_t d;

    // Level changes once stages 1 and 2 agree
    always_comb
    begin
        d = q;
        d.stage = {q.stage[1:0], pin_in};
        d.fall = 1'b0;
        if ((q.stage[1] == q.stage[2]) && (q.stage[2] != q.level))
        begin
            d.level = q.stage[2];
            d.fall = q.level & ~q.stage[2];
        end
    end

    // Pins idle high, so reset assumes high
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            q <= '{stage: 3'h7, level: 1'b1, fall: 1'b0};
        else
            q <= d;
    end

    assign level_out = q.level;
    assign fall_out  = q.fall;

endmodule
`default_nettype wire

// >>> verilog/ttcr_prescale.sv
// Machine-cycle and state-time tick generator
`timescale 1ns/100ps
`default_nettype none
module ttcr_prescale
    import ttcr_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Ticks, one cycle each
    output logic      machine_tick_out,
    output logic      state_tick_out
);

    typedef struct packed {
        logic [3:0] machine;   // Oscillator divide by twelve
        logic [3:0] state;     // Oscillator divide by two
        logic       machine_tick;
        logic       state_tick;
    } ttcr_pre_t;

    ttcr_pre_t q;
    ttcr_pre_t d;

    // Free-running dividers
    always_comb
    begin
        d = q;
        d.machine_tick = (q.machine == MACHINE_LAST);
        d.state_tick = (q.state == STATE_LAST);
        d.machine = d.machine_tick ? 4'h0 : q.machine + 4'h1;
        d.state = d.state_tick ? 4'h0 : q.state + 4'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign machine_tick_out = q.machine_tick;
    assign state_tick_out   = q.state_tick;

endmodule
`default_nettype wire

// >>> test/ttcr_pin_model.sv
// Far-side model: trigger pin, count pin and first auxiliary timer
`timescale 1ns/100ps
`default_nettype none
module ttcr_pin_model
(
    // Clock
    input  wire logic clk_in,
    // Pins and overflow pulse towards the timer
    output logic      trig_pin_out,
    output logic      count_pin_out,
    output logic      aux_ovf_out
);
    // Pins idle high, as pulled-up port lines do
    initial
    begin
        trig_pin_out  = 1'b1;
        count_pin_out = 1'b1;
        aux_ovf_out   = 1'b0;
    end

    task automatic set_dir(input logic up);
        @(posedge clk_in);
        trig_pin_out <= up;
    endtask

    // one falling edge; held four cycles so the synchroniser sees it
    task automatic trig_fall();
        @(posedge clk_in);
        trig_pin_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        trig_pin_out <= 1'b1;
        repeat (4) @(posedge clk_in);
    endtask

    // Count pulses, three cycles low and four high
    task automatic count_pulses(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            count_pin_out <= 1'b0;
            repeat (3) @(posedge clk_in);
            count_pin_out <= 1'b1;
            repeat (3) @(posedge clk_in);
        end
    endtask

    // One-cycle overflow pulse of the other timer
    task automatic aux_pulse();
        @(posedge clk_in);
        aux_ovf_out <= 1'b1;
        @(posedge clk_in);
        aux_ovf_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/test_third_timer_capture_reload.sv
// Self-checking bench for the third timer
`timescale 1ns/100ps
`default_nettype none
module test_third_timer_capture_reload
    import ttcr_pkg::*;
;
    // Clock, reset, register port
    logic       clk_in   = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [2:0] addr_in  = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in    = 1'b0;
    logic       rd_in    = 1'b0;
    logic [7:0] rdata_out;
    // Pins and serial side
    logic       trig_pin, count_pin, aux_ovf;
    logic       rx_baud_tick_out, tx_baud_tick_out, timer_irq_out;
    // Tallies
    int         fails = 0;
    int         comparisons = 0;
    int         rx_n = 0;
    int         tx_n = 0;
    logic [15:0] v, c;
    logic [7:0]  b;

    // 25 ns clock
    always #12.5 clk_in = ~clk_in;

    // Serial tick tallies, compared as differences
    always @(posedge clk_in)
    begin
        if (rx_baud_tick_out === 1'b1)
            rx_n++;
        if (tx_baud_tick_out === 1'b1)
            tx_n++;
    end

    ttcr_pin_model u_pins (.clk_in(clk_in), .trig_pin_out(trig_pin),
        .count_pin_out(count_pin), .aux_ovf_out(aux_ovf));

    ttcr_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .external_trigger_pin_in(trig_pin), .external_count_pin_in(count_pin),
        .aux_timer_ovf_in(aux_ovf), .rx_baud_tick_out(rx_baud_tick_out),
        .tx_baud_tick_out(tx_baud_tick_out), .timer_irq_out(timer_irq_out));

    // Exact compare
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Window compare, for counts whose prescaler phase is unknown
    task automatic rng(input string n, input logic [15:0] lo, input logic [15:0] hi,
                       input logic [15:0] g);
        comparisons++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            fails++;
            $display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask

    // One-cycle write
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    // One-cycle read; data stand only in the next cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask

    // Byte pairs, low byte first
    task automatic wr16(input logic [2:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(3'(a + 3'h1), d[15:8]);
    endtask

    task automatic rd16(input logic [2:0] a, output logic [15:0] d);
        logic [7:0] lo, hi;
        rd(a, lo);
        rd(3'(a + 3'h1), hi);
        d = {hi, lo};
    endtask

    // Bounded wait for the shared request
    task automatic wait_irq(input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge clk_in);
            if (timer_irq_out === 1'b1)
                return;
        end
        fails++;
        $display("[FAIL] timer_irq_out expected 1 seen %b", timer_irq_out);
        conclude();
    endtask

    // Reset values, unmapped places
    task automatic s_reset();
        wr(3'h7, 8'hff);
        rd(ADDR_CONTROL, b); chk("control", 16'h0000, b);
        rd(ADDR_MODE, b); chk("mode", 16'h0000, b);
        rd16(ADDR_COUNT_LOW, v); chk("count", 16'h0000, v);
        rd16(ADDR_RELOAD_LOW, v); chk("reload", 16'h0000, v);
        rd(3'h7, b); chk("unmapped", 16'h0000, b);
    endtask

    // Run bit gates a timer ticking every twelve clocks
    task automatic s_run();
        wr(ADDR_CONTROL, 8'h00);
        repeat (60) @(posedge clk_in);
        rd16(ADDR_COUNT_LOW, v); chk("stopped count", 16'h0000, v);
        wr(ADDR_CONTROL, 8'h04);
        repeat (120) @(posedge clk_in);
        wr(ADDR_CONTROL, 8'h00);
        rd16(ADDR_COUNT_LOW, v); rng("timer count", 16'h0009, 16'h000b, v);
    endtask

    // Up auto-reload overflow
    task automatic s_up();
        wr16(ADDR_RELOAD_LOW, 16'h1234);
        wr16(ADDR_COUNT_LOW, 16'hfff0);
        wr(ADDR_CONTROL, 8'h04);
        wait_irq(240);
        rd(ADDR_CONTROL, b); chk("up flags", 16'h0084, b);
        wr(ADDR_CONTROL, 8'h00);
        rd16(ADDR_COUNT_LOW, v); rng("reloaded", 16'h1234, 16'h1235, v);
        chk("irq cleared", 16'h0000, timer_irq_out);
    endtask

    // Capture: free overflow, ignored edge, real capture
    task automatic s_capture();
        wr16(ADDR_RELOAD_LOW, 16'h7777);
        wr16(ADDR_COUNT_LOW, 16'hfffe);
        wr(ADDR_CONTROL, 8'h05);
        wait_irq(60);
        rd(ADDR_CONTROL, b); chk("capture ovf", 16'h0085, b);
        wr(ADDR_CONTROL, 8'h01);
        rd16(ADDR_COUNT_LOW, v); rng("wrapped", 16'h0000, 16'h0001, v);
        wr16(ADDR_COUNT_LOW, 16'h4000);
        wr(ADDR_CONTROL, 8'h05);
        u_pins.trig_fall();
        rd16(ADDR_RELOAD_LOW, v); chk("no capture", 16'h7777, v);
        wr(ADDR_CONTROL, 8'h0d);
        u_pins.trig_fall();
        wait_irq(20);
        rd(ADDR_CONTROL, b); chk("capture flags", 16'h004d, b);
        wr(ADDR_CONTROL, 8'h09);
        rd16(ADDR_RELOAD_LOW, c); rng("captured", 16'h4000, 16'h4010, c);
        rd16(ADDR_COUNT_LOW, v); rng("kept counting", c, c + 16'h0001, v);
    endtask

    // Trigger reload in up mode, flag held until written
    task automatic s_trig();
        wr(ADDR_CONTROL, 8'h08);
        wr16(ADDR_RELOAD_LOW, 16'h0102);
        wr16(ADDR_COUNT_LOW, 16'h5555);
        u_pins.trig_fall();
        rd16(ADDR_COUNT_LOW, v); chk("trigger reload", 16'h0102, v);
        rd(ADDR_CONTROL, b); chk("external flag", 16'h0048, b);
        chk("irq external", 16'h0001, timer_irq_out);
        wr(ADDR_CONTROL, 8'h08);
        rd(ADDR_CONTROL, b); chk("flag cleared", 16'h0008, b);
    endtask

    // Down then up with down-count enabled
    task automatic s_down();
        wr(ADDR_MODE, 8'h01);
        wr16(ADDR_RELOAD_LOW, 16'h0010);
        wr16(ADDR_COUNT_LOW, 16'h0013);
        u_pins.set_dir(1'b0);
        wr(ADDR_CONTROL, 8'h04);
        wait_irq(100);
        rd(ADDR_CONTROL, b); chk("underflow", 16'h00c4, b);
        wr(ADDR_CONTROL, 8'h40);
        rd16(ADDR_COUNT_LOW, v); chk("top loaded", 16'hffff, v);
        chk("no ext irq", 16'h0000, timer_irq_out);
        u_pins.set_dir(1'b1);
        wr16(ADDR_COUNT_LOW, 16'hfffe);
        wr(ADDR_CONTROL, 8'h44);
        wait_irq(60);
        rd(ADDR_CONTROL, b); chk("overflow up", 16'h0084, b);
        wr(ADDR_CONTROL, 8'h00);
        rd16(ADDR_COUNT_LOW, v); chk("up reload", 16'h0010, v);
        wr(ADDR_MODE, 8'h00);
    endtask

    // Baud ticks from own overflow or from the other timer
    task automatic s_baud();
        int r0, t0;
        wr16(ADDR_RELOAD_LOW, 16'hfff0);
        wr16(ADDR_COUNT_LOW, 16'hfff0);
        r0 = rx_n;
        t0 = tx_n;
        wr(ADDR_CONTROL, 8'h35);
        repeat (160) @(posedge clk_in);
        rng("rx own", 16'd4, 16'd6, 16'(rx_n - r0));
        rng("tx own", 16'd4, 16'd6, 16'(tx_n - t0));
        rd(ADDR_CONTROL, b); chk("baud no flag", 16'h0035, b);
        // Stopped baud mode: enabled edge sets flag but never reloads
        wr(ADDR_CONTROL, 8'h38);
        wr16(ADDR_COUNT_LOW, 16'h5555);
        u_pins.trig_fall();
        rd16(ADDR_COUNT_LOW, v); chk("baud no reload", 16'h5555, v);
        rd(ADDR_CONTROL, b); chk("baud edge flag", 16'h0078, b);
        wr(ADDR_CONTROL, 8'h00);
        repeat (3) @(posedge clk_in);
        r0 = rx_n;
        t0 = tx_n;
        repeat (3) u_pins.aux_pulse();
        repeat (3) @(posedge clk_in);
        chk("rx aux", 16'd3, 16'(rx_n - r0));
        chk("tx aux", 16'd3, 16'(tx_n - t0));
    endtask

    // Counter mode counts pin falls
    task automatic s_counter();
        wr16(ADDR_COUNT_LOW, 16'h0000);
        wr(ADDR_CONTROL, 8'h06);
        u_pins.count_pulses(5);
        repeat (6) @(posedge clk_in);
        wr(ADDR_CONTROL, 8'h00);
        rd16(ADDR_COUNT_LOW, v); chk("pin count", 16'h0005, v);
    endtask

    // Verdict
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_reset();
        s_run();
        s_up();
        s_capture();
        s_trig();
        s_down();
        s_baud();
        s_counter();
        conclude();
    end
endmodule
`default_nettype wire
